// *** sim/dmrb_checker.sv ***
// Purpose: port-level assertions for the mode-register bank
// Assumes: single ref_clk domain, synchronous active-high rst
// Notes: bound into every dmrb_bank instance
`timescale 1ns/10ps
module dmrb_checker
   import dmrb_pkg::*;
(
   input wire logic                       ref_clk,
   input wire logic                       rst,
   input wire dmrb_pkg::dmrb_cmd_type     mr_cmd,
   input wire logic                       mr_read_valid,
   input wire logic [7:0]                 mr_read_data,
   input wire logic                       write_set_point_select,
   input wire logic                       operating_set_point_select,
   input wire logic [7:0]                 bank_repair_available,
   input wire dmrb_pkg::dmrb_access_type  access_cmd,
   input wire logic                       read_burst_end,
   input wire dmrb_pkg::dmrb_burst_cfg_type active_burst_cfg,
   input wire logic                       access_burst_32,
   input wire logic                       strobe_extra_edge,
   input wire logic                       factory_trim_fallback,
   input wire logic                       ignore_impedance_cal,
   input wire logic [7:0]                 row_hammer_refresh_control
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   wire logic rd_cmd = mr_cmd.valid && !mr_cmd.write;
   wire logic rh_wr = mr_cmd.valid && mr_cmd.write && mr_cmd.addr == ADDR_ROW_HAMMER_CONTROL;
   wire logic cfg_wr = mr_cmd.valid && mr_cmd.write && mr_cmd.addr == ADDR_BURST_STROBE_CONFIG;
   wire logic burst_mode_32 = active_burst_cfg.burst_length_field == BURST_FIXED_32;
   wire logic burst_mode_cmd = active_burst_cfg.burst_length_field == BURST_PER_COMMAND;
   property p_read_answer; rd_cmd |=> mr_read_valid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read unanswered");
   property p_read_cause; mr_read_valid |-> $past(rd_cmd); endproperty
   a_read_cause: assert property (p_read_cause) else $error("read answer without read");
   property p_info_rsvd;
      mr_read_valid && $past(mr_cmd.addr) == ADDR_DEVICE_INFORMATION
         |-> mr_read_data[7:5] == 3'h0 && !mr_read_data[2];
   endproperty
   a_info_rsvd: assert property (p_info_rsvd) else $error("reserved bits not zero");
   property p_repair;
      mr_read_valid && $past(mr_cmd.addr) == ADDR_REPAIR_RESOURCES
         |-> mr_read_data == $past(bank_repair_available);
   endproperty
   a_repair: assert property (p_repair) else $error("repair bits wrong");
   property p_rh_hold; !rh_wr |=> $stable(row_hammer_refresh_control); endproperty
   a_rh_hold: assert property (p_rh_hold) else $error("row control changed");
   property p_fallback; factory_trim_fallback |-> ignore_impedance_cal; endproperty
   a_fallback: assert property (p_fallback) else $error("calibration not ignored");
   property p_burst32; access_cmd.valid && burst_mode_32 |=> access_burst_32; endproperty
   a_burst32: assert property (p_burst32) else $error("fixed 32 not used");
   property p_on_cmd;
      access_cmd.valid && burst_mode_cmd |=> access_burst_32 == $past(access_cmd.burst_bit);
   endproperty
   a_on_cmd: assert property (p_on_cmd) else $error("per-command length wrong");
   property p_extra; strobe_extra_edge |-> $past(read_burst_end); endproperty
   a_extra: assert property (p_extra) else $error("stray strobe edge");
   property p_inactive;
      (cfg_wr && write_set_point_select != operating_set_point_select
         && $stable(operating_set_point_select)) ##1 $stable(operating_set_point_select)
         |=> $stable(active_burst_cfg);
   endproperty
   a_inactive: assert property (p_inactive) else $error("inactive copy disturbed");
   c_read: cover property (rd_cmd ##1 mr_read_valid);
   c_fallback: cover property ($rose(factory_trim_fallback));
   c_extra: cover property (strobe_extra_edge);
endmodule // dmrb_checker
bind dmrb_bank dmrb_checker u_chk (.ref_clk, .rst, .mr_cmd, .mr_read_valid, .mr_read_data,
   .write_set_point_select, .operating_set_point_select, .bank_repair_available, .access_cmd,
   .read_burst_end, .active_burst_cfg, .access_burst_32, .strobe_extra_edge,
   .factory_trim_fallback, .ignore_impedance_cal, .row_hammer_refresh_control);

// *** sim/dmrb_ctrl_model.sv ***
// Purpose: controller model issuing mode-register commands to the bank
// Assumes: commands launched 1 ns after the rising edge, at most one per call; writes to 1Ah-1Dh, 1Fh, 21h-26h, 29h-3Fh are dropped
// Notes: idle address and operand show the inverse of the last command
`timescale 1ns/10ps
module dmrb_ctrl_model
   import dmrb_pkg::*;
(
   input  wire logic                  ref_clk,
   output dmrb_pkg::dmrb_cmd_type     mr_cmd,
   input  wire logic                  mr_read_valid,
   input  wire logic [7:0]            mr_read_data
);
   initial mr_cmd = '0;
   // operand passed as given; callers may set reserved_future bits, as t_regs does writing 8'hFF to read-only addresses
   task automatic mr_access(input logic wr, input logic [5:0] addr, input logic [7:0] op,
                            output logic [7:0] data, output logic got);
      got = 1'b0;
      data = 8'h00;
      if (wr && (addr inside {[6'h1A:6'h1D], 6'h1F, [6'h21:6'h26], [6'h29:6'h3F]}))
         return;
      @(posedge ref_clk);
      #1 mr_cmd = '{1'b1, wr, addr, op};
      @(posedge ref_clk);
      #1 got = mr_read_valid;
      data = mr_read_data;
      mr_cmd = '{1'b0, ~wr, ~addr, ~op};
   endtask
endmodule // dmrb_ctrl_model

// *** sim/tb.sv ***
// Purpose: self-checking bench for the mode-register bank
// Assumes: 100 MHz ref_clk, inputs driven 1 ns after the rising edge
// Notes: a read of reserved address 1Ah is issued but not judged
`timescale 1ns/10ps
module tb;
   import dmrb_pkg::*;
   logic               ref_clk = 1'b0;
   logic               rst = 1'b1;
   dmrb_cmd_type       mr_cmd;
   logic               mr_read_valid;
   logic [7:0]         mr_read_data;
   logic               write_set_point_select = 1'b0;
   logic               operating_set_point_select = 1'b0;
   logic               cal_start_done = 1'b0;
   logic               cal_latch_done = 1'b0;
   logic [1:0]         zq_pin_sense = 2'h0;
   logic [7:0]         bank_repair_available = 8'hB6;
   dmrb_access_type    access_cmd = '0;
   logic               write_burst_end = 1'b0;
   logic               read_burst_end = 1'b0;
   dmrb_burst_cfg_type active_burst_cfg;
   logic               access_burst_32, precharge_start, strobe_extra_edge;
   logic               factory_trim_fallback, ignore_impedance_cal;
   logic [7:0]         strobe_osc_runtime, row_hammer_refresh_control;
   logic [7:0]         calibration_pattern_a, calibration_pattern_b;
   logic [7:0]         d;
   logic               g;
   int                 errors = 0;
   int                 samples_checked = 0;
   int                 wr_clk [8] = '{6, 10, 16, 20, 24, 30, 34, 40};
   logic [5:0]         ro [4] = '{ADDR_DEVICE_INFORMATION, ADDR_REPAIR_RESOURCES,
                                  ADDR_TEST_RESERVED_A, ADDR_TEST_RESERVED_B};
   dmrb_bank dut (.ref_clk, .rst, .mr_cmd, .mr_read_valid, .mr_read_data,
      .write_set_point_select, .operating_set_point_select, .cal_start_done, .cal_latch_done,
      .zq_pin_sense, .bank_repair_available, .access_cmd, .write_burst_end, .read_burst_end,
      .active_burst_cfg, .access_burst_32, .precharge_start, .strobe_extra_edge,
      .factory_trim_fallback, .ignore_impedance_cal, .strobe_osc_runtime,
      .row_hammer_refresh_control, .calibration_pattern_a, .calibration_pattern_b);
   dmrb_ctrl_model ctrl (.ref_clk, .mr_cmd, .mr_read_valid, .mr_read_data);
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check_val(input string what, input logic [10:0] exp, input logic [10:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_count(input string what, input int exp, input int got);
      samples_checked++;
      if (got != exp) begin
         errors++;
         $display("wrong value %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   function automatic dmrb_burst_cfg_type exp_cfg(input logic [7:0] op);
      exp_cfg = '{op[1:0], op[2], op[3], 6'(wr_clk[op[6:4]]), op[7]};
   endfunction
   task automatic do_reset;
      @(posedge ref_clk);
      #1 rst = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 rst = 1'b0;
   endtask
   task automatic pulse(ref logic s);
      @(posedge ref_clk);
      #1 s = 1'b1;
      @(posedge ref_clk);
      #1 s = 1'b0;
   endtask
   task automatic t_selftest;
      for (int k = 0; k < 4; k++) begin
         zq_pin_sense = 2'(k);
         do_reset;
         pulse(cal_latch_done);
         repeat (6) @(posedge ref_clk);
         ctrl.mr_access(1'b0, ADDR_DEVICE_INFORMATION, 8'h00, d, g);
         check_val("info before start", 11'h100, {2'b0, g, d});
         pulse(cal_start_done);
         pulse(cal_latch_done);
         // read taken two edges after the latch, inside the latch wait
         ctrl.mr_access(1'b0, ADDR_DEVICE_INFORMATION, 8'h00, d, g);
         check_val("info in latch wait", 11'h100, {2'b0, g, d});
         repeat (3) @(posedge ref_clk);
         ctrl.mr_access(1'b0, ADDR_DEVICE_INFORMATION, 8'h00, d, g);
         check_val("info result", {3'h1, 3'h0, 2'(k), 3'h0}, {2'b0, g, d});
         check_val("fallback", 11'(k == 1 || k == 2), factory_trim_fallback);
         check_val("ignore cal", 11'(k == 1 || k == 2), ignore_impedance_cal);
      end
      do_reset;
      ctrl.mr_access(1'b0, ADDR_DEVICE_INFORMATION, 8'h00, d, g);
      check_val("info after reset", 11'h100, {2'b0, g, d});
      check_val("fallback cleared", 11'h000, factory_trim_fallback);
      $display("test selftest done");
   endtask
   task automatic t_regs;
      check_val("cfg reset", exp_cfg(BURST_CONFIG_RESET), active_burst_cfg);
      ctrl.mr_access(1'b1, ADDR_STROBE_OSC_RUNTIME, 8'hA5, d, g);
      ctrl.mr_access(1'b1, ADDR_ROW_HAMMER_CONTROL, 8'h3C, d, g);
      ctrl.mr_access(1'b1, ADDR_CAL_PATTERN_A, 8'h5A, d, g);
      ctrl.mr_access(1'b1, ADDR_CAL_PATTERN_B, 8'hC3, d, g);
      // write-only patterns only visible at the ports, never by read
      foreach (ro[j]) ctrl.mr_access(1'b1, ro[j], 8'hFF, d, g);
      check_val("osc runtime", 11'hA5, strobe_osc_runtime);
      check_val("pattern a", 11'h5A, calibration_pattern_a);
      check_val("pattern b", 11'hC3, calibration_pattern_b);
      check_val("row port", 11'h03C, row_hammer_refresh_control);
      check_val("cfg kept", exp_cfg(BURST_CONFIG_RESET), active_burst_cfg);
      ctrl.mr_access(1'b0, ADDR_ROW_HAMMER_CONTROL, 8'h00, d, g);
      check_val("row control", 11'h13C, {2'b0, g, d});
      ctrl.mr_access(1'b0, ADDR_REPAIR_RESOURCES, 8'h00, d, g);
      check_val("repair", 11'h1B6, {2'b0, g, d});
      ctrl.mr_access(1'b0, ADDR_DEVICE_INFORMATION, 8'h00, d, g);
      check_val("info kept", 11'h100, {2'b0, g, d});
      ctrl.mr_access(1'b0, 6'h1A, 8'h00, d, g);
      $display("test regs done");
   endtask
   task automatic t_burst;
      logic [7:0] op;
      logic [1:0] bl;
      int n;
      for (int i = 0; i < 8; i++) begin
         bl = 2'(i % 3);
         op = {i[0], 3'(i), i[1], 1'b1, bl};
         ctrl.mr_access(1'b1, ADDR_BURST_STROBE_CONFIG, op, d, g);
         @(posedge ref_clk);
         #1 check_val("cfg", exp_cfg(op), active_burst_cfg);
         for (int b = 0; b < 2; b++) begin
            @(posedge ref_clk);
            #1 access_cmd = '{1'b1, 1'b1, 1'b1, 1'(b)};
            @(posedge ref_clk);
            #1 access_cmd = '0;
            check_val("burst 32", 11'(bl == 1 || (bl == 2 && b == 1)), access_burst_32);
         end
         pulse(write_burst_end);
         n = 0;
         while (precharge_start !== 1'b1 && n < 60) begin
            @(posedge ref_clk);
            #1 n++;
         end
         check_count("precharge delay", wr_clk[i], n);
         if (n >= 60) wrap_up;
         pulse(read_burst_end);
         check_val("extra edge", 11'(i[0]), strobe_extra_edge);
      end
      $display("test burst done");
   endtask
   task automatic t_setpoint;
      @(posedge ref_clk);
      #1 write_set_point_select = 1'b1;
      ctrl.mr_access(1'b1, ADDR_BURST_STROBE_CONFIG, 8'hF6, d, g);
      repeat (3) @(posedge ref_clk);
      #1 check_val("running copy", exp_cfg(8'hFD), active_burst_cfg);
      operating_set_point_select = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1 check_val("copy one", exp_cfg(8'hF6), active_burst_cfg);
      operating_set_point_select = 1'b0;
      repeat (3) @(posedge ref_clk);
      #1 check_val("copy zero", exp_cfg(8'hFD), active_burst_cfg);
      $display("test setpoint done");
   endtask
   initial begin
      do_reset;
      t_selftest;
      t_regs;
      t_burst;
      t_setpoint;
      wrap_up;
   end
endmodule // tb

// *** src/dmrb_bank.sv ***
// Purpose: mode-register bank of a low-power dram, upper address map plus
//          device information and dual set-point burst configuration
// Assumes: one command per cycle on mr_cmd; set-point selects come from the
//          register-control logic elsewhere in the device
// Notes: read data is registered, one cycle after the read command
`timescale 1ns/10ps
module dmrb_bank #(
   parameter logic REFRESH_MODIFIED_ONLY = 1'b0,
   parameter logic BYTE_MODE_LATENCY     = 1'b0,
   parameter logic SELFTEST_SUPPORTED    = 1'b1
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst,
   input  wire dmrb_pkg::dmrb_cmd_type      mr_cmd,
   output logic                             mr_read_valid,
   output logic [7:0]                       mr_read_data,
   input  wire logic                        write_set_point_select,
   input  wire logic                        operating_set_point_select,
   input  wire logic                        cal_start_done,
   input  wire logic                        cal_latch_done,
   input  wire logic [1:0]                  zq_pin_sense,
   input  wire logic [7:0]                  bank_repair_available,
   input  wire dmrb_pkg::dmrb_access_type   access_cmd,
   input  wire logic                        write_burst_end,
   input  wire logic                        read_burst_end,
   output dmrb_pkg::dmrb_burst_cfg_type     active_burst_cfg,
   output logic                             access_burst_32,
   output logic                             precharge_start,
   output logic                             strobe_extra_edge,
   output logic                             factory_trim_fallback,
   output logic                             ignore_impedance_cal,
   output logic [7:0]                       strobe_osc_runtime,
   output logic [7:0]                       row_hammer_refresh_control,
   output logic [7:0]                       calibration_pattern_a,
   output logic [7:0]                       calibration_pattern_b
);
   import dmrb_pkg::*;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_STARTED,
      ST_LATCH_WAIT,
      ST_VALID
   } dmrb_selftest_type;

   dmrb_selftest_type selftest_state;
   dmrb_selftest_type next_selftest_state;

   logic [7:0] burst_copy [0:1];
   logic [7:0] active_raw;
   logic [1:0] zq_sync1;
   logic [1:0] zq_sync2;
   logic [1:0] zq_sync3;
   logic [1:0] zq_level;
   logic [1:0] resistor_selftest_result;
   logic [3:0] latch_wait;
   logic [5:0] recovery_left;
   logic       pending_ap;
   logic [7:0] next_read_data;
   logic [7:0] device_information;
   logic       assembly_error;

   wire mr_write = mr_cmd.valid & mr_cmd.write;
   wire mr_read  = mr_cmd.valid & ~mr_cmd.write;
   wire wr_burst_cfg  = mr_write & (mr_cmd.addr == ADDR_BURST_STROBE_CONFIG);
   wire wr_osc        = mr_write & (mr_cmd.addr == ADDR_STROBE_OSC_RUNTIME);
   wire wr_row_hammer = mr_write & (mr_cmd.addr == ADDR_ROW_HAMMER_CONTROL);
   wire wr_pattern_a  = mr_write & (mr_cmd.addr == ADDR_CAL_PATTERN_A);
   wire wr_pattern_b  = mr_write & (mr_cmd.addr == ADDR_CAL_PATTERN_B);
   // test addresses, read-only and reserved addresses decode to nothing

   // write_recovery_count lookup
   function automatic logic [5:0] recovery_clocks(input logic [2:0] code);
      case (code)
         3'h0:    recovery_clocks = 6'h06;
         3'h1:    recovery_clocks = 6'h0A;
         3'h2:    recovery_clocks = 6'h10;
         3'h3:    recovery_clocks = 6'h14;
         3'h4:    recovery_clocks = 6'h18;
         3'h5:    recovery_clocks = 6'h1E;
         3'h6:    recovery_clocks = 6'h22;
         default: recovery_clocks = 6'h28;
      endcase
   endfunction

   // two set-point copies, each written only when selected for writes
   genvar sp;
   generate
      for (sp = 0; sp < 2; sp++) begin : g_set_point
         always_ff @(posedge ref_clk) begin
            if (rst) begin
               burst_copy[sp] <= BURST_CONFIG_RESET;
            end else if (wr_burst_cfg && (write_set_point_select == 1'(sp))) begin
               burst_copy[sp] <= mr_cmd.op;
            end
         end
      end
   endgenerate

   // inactive copy never reaches the datapath
   assign active_raw = burst_copy[operating_set_point_select];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         active_burst_cfg <= '0;
      end else begin
         active_burst_cfg.burst_length_field    <= active_raw[POS_BURST_LO +: 2];
         active_burst_cfg.write_preamble_two    <= active_raw[POS_WR_PREAMBLE];
         active_burst_cfg.read_preamble_toggle  <= active_raw[POS_RD_PREAMBLE];
         active_burst_cfg.write_recovery_count  <=
            recovery_clocks(active_raw[POS_WR_RECOVERY +: 3]);
         active_burst_cfg.read_postamble_select <= active_raw[POS_RD_POSTAMBLE];
      end
   end

   // per-access burst length; reserved code falls back to 16
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         access_burst_32 <= 1'b0;
      end else if (access_cmd.valid) begin
         case (active_burst_cfg.burst_length_field)
            BURST_FIXED_32:    access_burst_32 <= 1'b1;
            BURST_PER_COMMAND: access_burst_32 <= access_cmd.burst_bit;
            default:           access_burst_32 <= 1'b0;
         endcase
      end
   end

   // auto_precharge write: precharge starts write_recovery_count clocks after burst end
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pending_ap <= 1'b0;
      end else if (access_cmd.valid && access_cmd.write) begin
         pending_ap <= access_cmd.auto_precharge;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         recovery_left   <= 6'h00;
         precharge_start <= 1'b0;
      end else begin
         precharge_start <= (recovery_left == 6'h01);
         if (write_burst_end && pending_ap) begin
            recovery_left <= active_burst_cfg.write_recovery_count;
         end else if (recovery_left != 6'h00) begin
            recovery_left <= recovery_left - 6'h01;
         end
      end
   end

   // extra strobe edge pair only with the long postamble
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         strobe_extra_edge <= 1'b0;
      end else begin
         strobe_extra_edge <= read_burst_end & active_burst_cfg.read_postamble_select;
      end
   end

   // resistor sense comes straight off a pin
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         zq_sync1 <= 2'h0;
         zq_sync2 <= 2'h0;
         zq_sync3 <= 2'h0;
         zq_level <= 2'h0;
      end else begin
         zq_sync1 <= zq_pin_sense;
         zq_sync2 <= zq_sync1;
         zq_sync3 <= zq_sync2;
         if (zq_sync2 == zq_sync3) begin
            zq_level <= zq_sync3;
         end
      end
   end

   // self-test sequence; either channel's events arrive merged on these pulses
   always_comb begin
      next_selftest_state = selftest_state;
      case (selftest_state)
         ST_IDLE:       if (cal_start_done && SELFTEST_SUPPORTED) next_selftest_state = ST_STARTED;
         ST_STARTED:    if (cal_latch_done) next_selftest_state = ST_LATCH_WAIT;
         ST_LATCH_WAIT: if (latch_wait == 4'h1) next_selftest_state = ST_VALID;
         ST_VALID:      next_selftest_state = ST_VALID;
         default:       next_selftest_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         selftest_state <= ST_IDLE;
      end else begin
         selftest_state <= next_selftest_state;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         latch_wait <= 4'h0;
      end else if (selftest_state == ST_STARTED && cal_latch_done) begin
         latch_wait <= 4'(CAL_LATCH_WAIT_CYCLES);
      end else if (latch_wait != 4'h0) begin
         latch_wait <= latch_wait - 4'h1;
      end
   end

   // result frozen when it becomes valid, cleared by reset
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         resistor_selftest_result <= SELFTEST_NOT_SUPPORTED;
      end else if (selftest_state == ST_LATCH_WAIT && next_selftest_state == ST_VALID) begin
         resistor_selftest_result <= zq_level;
      end
   end

   assign assembly_error = (resistor_selftest_result == SELFTEST_TIED_LOW) ||
                           (resistor_selftest_result == SELFTEST_SHORTED_HIGH);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         factory_trim_fallback <= 1'b0;
         ignore_impedance_cal  <= 1'b0;
      end else begin
         factory_trim_fallback <= assembly_error;
         ignore_impedance_cal  <= assembly_error;
      end
   end

   // plain storage registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         strobe_osc_runtime         <= REG_RESET;
         row_hammer_refresh_control <= REG_RESET;
         calibration_pattern_a      <= REG_RESET;
         calibration_pattern_b      <= REG_RESET;
      end else begin
         if (wr_osc) strobe_osc_runtime <= mr_cmd.op;
         if (wr_row_hammer) row_hammer_refresh_control <= mr_cmd.op;
         if (wr_pattern_a) calibration_pattern_a <= mr_cmd.op;
         if (wr_pattern_b) calibration_pattern_b <= mr_cmd.op;
      end
   end

   // unused bit positions stay zero
   always_comb begin
      device_information = 8'h00;
      device_information[POS_REFRESH_CAP]  = REFRESH_MODIFIED_ONLY;
      device_information[POS_LATENCY_MODE] = BYTE_MODE_LATENCY;
      device_information[POS_SELFTEST_LO +: 2] = resistor_selftest_result;
   end

   // write-only and reserved addresses read as zero, value not guaranteed
   always_comb begin
      case (mr_cmd.addr)
         ADDR_DEVICE_INFORMATION: next_read_data = device_information;
         ADDR_ROW_HAMMER_CONTROL: next_read_data = row_hammer_refresh_control;
         ADDR_REPAIR_RESOURCES:   next_read_data = bank_repair_available;
         default:                 next_read_data = READ_UNDEFINED;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         mr_read_valid <= 1'b0;
         mr_read_data  <= 8'h00;
      end else begin
         mr_read_valid <= mr_read;
         if (mr_read) mr_read_data <= next_read_data;
      end
   end

endmodule // dmrb_bank

// *** src/dmrb_pkg.sv ***
// Purpose: constants and types for the dram mode-register bank
// Assumes: 100 MHz ref_clk, 6-bit mode-register address, 8-bit operand
// Notes: reset value of the burst config keeps the two-clock write preamble
//
// Behaviour
// - registers read by mode-register read, written by mode-register write, 6-bit address
// - reserved_future bit positions read back as zero
// - reads of reserved or write-only addresses return undefined data
// - writes to read-only registers change nothing
// - device info bit 0 reports refresh capability
// - device info bit 1 reports normal or byte-mode latency
// - device info bits 4:3 report resistor self-test result
// - self-test valid after cal start, cal latch, latch wait; reset discards
// - on assembly error use factory trim and ignore impedance calibration
// - burst_length_field selects 16, 32, per-command; 11 reserved
// - per-command mode: command burst bit picks 16 or 32
// - write preamble bit 2 must be one, two-clock preamble
// - read preamble bit 3 selects static or toggling preamble
// - write_recovery_count codes map to 6,10,16,20,24,30,34,40 clocks
// - write_recovery_count sets clocks to internal precharge after auto_precharge write
// - read_postamble_select bit 7 selects half or one-and-half clock postamble
// - long postamble adds one extra strobe edge pair after burst
// - burst config has two set points; write hits write_set_point_select copy
// - device runs from operating_set_point_select copy; other copy ignored
// - address 17h write-only holds strobe oscillator run-time
// - address 18h read/write holds targeted_row_refresh control
// - addresses 20h and 28h write-only hold calibration patterns A and B
package dmrb_pkg;

   localparam logic [5:0] ADDR_DEVICE_INFORMATION   = 6'h00;
   localparam logic [5:0] ADDR_BURST_STROBE_CONFIG  = 6'h01;
   localparam logic [5:0] ADDR_STROBE_OSC_RUNTIME   = 6'h17;
   localparam logic [5:0] ADDR_ROW_HAMMER_CONTROL   = 6'h18;
   localparam logic [5:0] ADDR_REPAIR_RESOURCES     = 6'h19;
   localparam logic [5:0] ADDR_TEST_RESERVED_A      = 6'h1E;
   localparam logic [5:0] ADDR_CAL_PATTERN_A        = 6'h20;
   localparam logic [5:0] ADDR_TEST_RESERVED_B      = 6'h27;
   localparam logic [5:0] ADDR_CAL_PATTERN_B        = 6'h28;

   // device information field positions
   localparam int POS_REFRESH_CAP   = 0;
   localparam int POS_LATENCY_MODE  = 1;
   localparam int POS_SELFTEST_LO   = 3;

   // burst config field positions
   localparam int POS_BURST_LO      = 0;
   localparam int POS_WR_PREAMBLE   = 2;
   localparam int POS_RD_PREAMBLE   = 3;
   localparam int POS_WR_RECOVERY   = 4;
   localparam int POS_RD_POSTAMBLE  = 7;

   localparam logic [7:0] BURST_CONFIG_RESET = 8'h04;
   localparam logic [7:0] REG_RESET          = 8'h00;
   localparam logic [7:0] READ_UNDEFINED     = 8'h00;

   localparam logic [1:0] BURST_FIXED_16     = 2'h0;
   localparam logic [1:0] BURST_FIXED_32     = 2'h1;
   localparam logic [1:0] BURST_PER_COMMAND  = 2'h2;

   localparam logic [1:0] SELFTEST_NOT_SUPPORTED = 2'h0;
   localparam logic [1:0] SELFTEST_TIED_LOW      = 2'h1;
   localparam logic [1:0] SELFTEST_SHORTED_HIGH  = 2'h2;
   localparam logic [1:0] SELFTEST_RESISTOR_OK   = 2'h3;

   localparam int CLK_PERIOD_NS          = 10;
   localparam int CAL_LATCH_WAIT_NS      = 30;
   localparam int CAL_LATCH_WAIT_CYCLES  =
      (CAL_LATCH_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [5:0] addr;
      logic [7:0] op;
   } dmrb_cmd_type;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic       auto_precharge;
      logic       burst_bit;
   } dmrb_access_type;

   typedef struct packed {
      logic [1:0] burst_length_field;
      logic       write_preamble_two;
      logic       read_preamble_toggle;
      logic [5:0] write_recovery_count;
      logic       read_postamble_select;
   } dmrb_burst_cfg_type;

endpackage
